// [include/rcfc_pkg.sv]
/*
 ROM cache flush control package: register map, field positions, reset values
 and line-array geometry. Assumes a 32-bit Avalon-MM word-addressed by bytes.
*/
package rcfc_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [31:0] RCFC_CTRL_ADDR = 32'hfffc1400;
   localparam logic [31:0] RCFC_STAT_ADDR = 32'hfffc1404;
   localparam int RCFC_FLUSH_POS = 3;
   localparam int RCFC_FIXED_ONE_POS = 0;
   localparam logic [31:0] RCFC_CTRL_RESET = 32'h00000001;
   localparam logic [31:0] RCFC_UNMAPPED_DATA = 32'h00000000;
   // ---------------------------------------------------------------
   // line array and bus handshake states
   // ---------------------------------------------------------------
   localparam int RCFC_LINES = 16;
   localparam int RCFC_IDX_W = 4;
   localparam logic [RCFC_IDX_W-1:0] RCFC_LAST_LINE = 4'hf;
   typedef enum logic [1:0] {RCFC_BUS_IDLE, RCFC_BUS_ANSWER} rcfc_bus_t;
endpackage

// [src/rcfc_line_valid.sv]
/*
 Valid bits of the ROM cache lines, one flip-flop per line, addressed by index.
 Assumes the cache fill logic outside presents a one-cycle fill strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module rcfc_line_valid
   import rcfc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic inval_all_i,
   input wire logic fill_i,
   input wire logic [RCFC_IDX_W-1:0] fill_idx_i,
   output logic [RCFC_LINES-1:0] valid_o
);
   typedef struct packed {
      logic [RCFC_LINES-1:0] valid;
   } rcfc_lv_state_t;
   rcfc_lv_state_t st;
   rcfc_lv_state_t next_st;

   always_comb begin
      next_st = st;
      if (fill_i) begin
         next_st.valid[fill_idx_i] = 1'b1;
      end
      // invalidation wins over a fill in the same cycle
      if (inval_all_i) begin
         next_st.valid = '0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign valid_o = st.valid;

   a_inval_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      inval_all_i |=> (valid_o == '0))
      else $error("line stayed valid after invalidate");
endmodule
`default_nettype wire

// [src/rcfc_top.sv]
/*
 ROM cache flush control: control register on Avalon-MM plus line-valid array.
 Assumes 32-bit accesses only and a standby entry level from the power manager.
*/
`timescale 1ns/10ps
`default_nettype none
module rcfc_top
   import rcfc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic standby_i,
   input wire logic [31:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic fill_i,
   input wire logic [RCFC_IDX_W-1:0] fill_idx_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [RCFC_LINES-1:0] line_valid_o,
   output logic flush_pulse_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      rcfc_bus_t bus;
      logic waitreq;
      logic flush_bit;
      logic [31:0] rdata;
      logic [15:0] flush_count;
   } rcfc_state_t;
   rcfc_state_t st;
   rcfc_state_t next_st;
   logic [RCFC_LINES-1:0] valid;

   function automatic logic [31:0] ctrl_read_value();
      logic [31:0] v;
      v = '0;
      v[RCFC_FIXED_ONE_POS] = 1'b1;
      // flush bit intentionally absent from the read value
      return v;
   endfunction

   logic take;
   logic flush_req;
   assign take = (st.bus == RCFC_BUS_IDLE) && (avs_read_i || avs_write_i);
   // only full longword writes act; partial writes are ignored
   assign flush_req = take && avs_write_i && (avs_address_i == RCFC_CTRL_ADDR)
      && (avs_byteenable_i == 4'hf) && avs_writedata_i[RCFC_FLUSH_POS];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.flush_bit = 1'b0;
      unique case (st.bus)
         RCFC_BUS_IDLE: begin
            if (take) begin
               next_st.bus = RCFC_BUS_ANSWER;
               next_st.waitreq = 1'b0;
               next_st.rdata = RCFC_UNMAPPED_DATA;
               if (avs_read_i && avs_address_i == RCFC_CTRL_ADDR) begin
                  next_st.rdata = ctrl_read_value();
               end else if (avs_read_i && avs_address_i == RCFC_STAT_ADDR) begin
                  next_st.rdata = {st.flush_count, valid};
               end
            end
         end
         RCFC_BUS_ANSWER: begin
            next_st.bus = RCFC_BUS_IDLE;
            next_st.waitreq = 1'b1;
         end
      endcase
      // the bit self-clears after one cycle, so the flush is a single strobe
      if (flush_req) begin
         next_st.flush_bit = 1'b1;
         next_st.flush_count = 16'(st.flush_count + 16'h0001);
      end
      if (standby_i) begin
         next_st.flush_bit = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '{bus: RCFC_BUS_IDLE, waitreq: 1'b1, flush_bit: 1'b0, rdata: 32'h00000000,
                 flush_count: 16'h0000};
      end else begin
         st <= next_st;
      end
   end

   rcfc_line_valid rcfc_line_valid_i (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .inval_all_i(st.flush_bit),
      .fill_i(fill_i),
      .fill_idx_i(fill_idx_i),
      .valid_o(valid)
   );

   assign avs_readdata_o = st.rdata;
   // registered so the bus sees no decode glitch on waitrequest
   assign avs_waitrequest_o = st.waitreq;
   assign line_valid_o = valid;
   assign flush_pulse_o = st.flush_bit;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_flush_reaches_lines: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      flush_req && !standby_i |=> flush_pulse_o ##1 (line_valid_o == '0))
      else $error("flush write did not clear lines");
   a_zero_no_flush: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (take && avs_write_i && !avs_writedata_i[RCFC_FLUSH_POS]) |=> !flush_pulse_o)
      else $error("zero write flushed");
   a_ctrl_reads_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (take && avs_read_i && avs_address_i == RCFC_CTRL_ADDR)
      |=> (avs_readdata_o == RCFC_CTRL_RESET) && !avs_waitrequest_o)
      else $error("control read value wrong");
   a_self_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      flush_pulse_o && !flush_req |=> !flush_pulse_o)
      else $error("flush bit did not self-clear");
   a_standby_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      standby_i |=> !flush_pulse_o)
      else $error("standby left flush bit set");
   a_partial_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (take && avs_write_i && avs_byteenable_i != 4'hf) |=> !flush_pulse_o)
      else $error("partial write acted");
   a_answer_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      take |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("answer timing wrong");
   a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!avs_waitrequest_o && $past(avs_address_i) == RCFC_CTRL_ADDR)
      |-> (avs_readdata_o[31:1] == 31'h00000000))
      else $error("reserved bits not zero");
   c_flush: cover property (@(posedge clk_i) disable iff (!rst_n_i) flush_req);
   c_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      take && avs_read_i && avs_address_i == RCFC_STAT_ADDR);
   c_fill_flush: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      fill_i && flush_pulse_o);
endmodule
`default_nettype wire

// [test/tb_rom_cache_flush_control.sv]
/*
 self-checking bench for rcfc_top: drives Avalon-MM, fill and standby itself.
 assumes the design answers every request; the cycle ceiling catches a hang.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_rom_cache_flush_control
   import rcfc_pkg::*;
;
   logic clk_i, rst_n_i, standby_i, avs_read_i, avs_write_i, fill_i;
   logic [31:0] avs_address_i, avs_writedata_i, avs_readdata_o, q;
   logic [3:0] avs_byteenable_i;
   logic [RCFC_IDX_W-1:0] fill_idx_i;
   logic avs_waitrequest_o, flush_pulse_o, fp;
   logic [RCFC_LINES-1:0] line_valid_o;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   rcfc_top rcfc_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .standby_i(standby_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .fill_i(fill_i), .fill_idx_i(fill_idx_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .line_valid_o(line_valid_o),
      .flush_pulse_o(flush_pulse_o));
   // ---------------------------------------------------------------
   // clock, timeout, verdict
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic summarize;
      if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // ---------------------------------------------------------------
   // bus cycle and fill helpers
   // ---------------------------------------------------------------
   // request held until waitrequest is seen low at a rising edge; legal calls
   // pass all four lanes, longword only
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      do begin
         @(posedge clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      fp = flush_pulse_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic fill_all;
      for (int i = 0; i < RCFC_LINES; i++) begin
         @(posedge clk_i);
         fill_i <= 1'b1;
         fill_idx_i <= i[RCFC_IDX_W-1:0];
      end
      @(posedge clk_i);
      fill_i <= 1'b0;
      @(posedge clk_i);
      chk(32'(line_valid_o), 32'h0000ffff);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_flush;
      fill_all();
      bus(1'b0, RCFC_STAT_ADDR, 32'h0, 4'hf);
      chk(q, 32'h0000ffff);
      // flush that software issues after a flash_memory_array switch
      bus(1'b1, RCFC_CTRL_ADDR, 32'h00000009, 4'hf);
      chk(32'(fp), 32'h1);
      @(posedge clk_i);
      chk(32'(line_valid_o), 32'h0);
      bus(1'b0, RCFC_CTRL_ADDR, 32'h0, 4'hf);
      chk(q, 32'h00000001);
      bus(1'b0, RCFC_STAT_ADDR, 32'h0, 4'hf);
      chk(q, 32'h00010000);
   endtask
   task automatic t_zero_and_reserved;
      fill_all();
      bus(1'b1, RCFC_CTRL_ADDR, 32'h00000001, 4'hf);
      chk(32'(fp), 32'h0);
      bus(1'b1, RCFC_CTRL_ADDR, 32'h00000001, 4'hf);
      chk(32'(fp), 32'h0);
      bus(1'b0, RCFC_CTRL_ADDR, 32'h0, 4'hf);
      chk(q, 32'h00000001);
      chk(32'(line_valid_o), 32'h0000ffff);
   endtask
   task automatic t_standby_partial;
      @(posedge clk_i);
      standby_i <= 1'b1;
      bus(1'b1, RCFC_CTRL_ADDR, 32'h00000009, 4'hf);
      chk(32'(fp), 32'h0);
      @(posedge clk_i);
      standby_i <= 1'b0;
      chk(32'(line_valid_o), 32'h0000ffff);
      bus(1'b1, RCFC_CTRL_ADDR, 32'h00000009, 4'h1);
      chk(32'(fp), 32'h0);
      bus(1'b0, 32'hfffc1408, 32'h0, 4'hf);
      chk(q, RCFC_UNMAPPED_DATA);
   endtask
   initial begin
      {rst_n_i, standby_i, avs_read_i, avs_write_i, fill_i} = 5'h0;
      avs_address_i = 32'h0;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'hf;
      fill_idx_i = '0;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      chk(32'(line_valid_o), 32'h0);
      chk(32'(flush_pulse_o), 32'h0);
      chk(32'(avs_waitrequest_o), 32'h1);
      bus(1'b0, RCFC_CTRL_ADDR, 32'h0, 4'hf);
      chk(q, RCFC_CTRL_RESET);
      t_flush();
      t_zero_and_reserved();
      t_standby_partial();
      summarize();
   end
endmodule
`default_nettype wire
